// file: design/sjmcs_selector.sv
// motor and clutch selector with panel control and position feedback
`timescale 1ns/1ns
module sjmcs_selector #(
  parameter int unsigned     ACK_TMO_CYC    = sjmcs_pkg::ACK_TMO_CYC,
  parameter longint unsigned PANEL_IDLE_CYC = sjmcs_pkg::PANEL_IDLE_CYC
) (
  // clock and reset
  input  wire  logic                clk,
  input  wire  logic                sys_rst,
  // register port
  input  wire  logic [3:0]          reg_addr,
  input  wire  logic [15:0]         reg_wdata,
  input  wire  logic                reg_wr,
  input  wire  logic                reg_rd,
  output logic       [15:0]         reg_rdata,
  // operator panel pins
  input  wire  logic [1:0]          mode_sw,
  input  wire  logic                panel_go,
  input  wire  logic [5:0]          panel_dev,
  input  wire  logic [1:0]          panel_spd,
  input  wire  logic [1:0]          panel_dir,
  output logic                      panel_enabled,
  // acknowledge pins from device, clutches and motor
  input  wire  logic                dev_ack,
  input  wire  logic [1:0]          clutch_ack,
  input  wire  logic                motor_ack,
  // drive outputs
  output logic [5:0]                dev_sel,
  output logic                      dev_sel_en,
  output logic [1:0]                clutch_on,
  output logic                      motor_on,
  output logic                      motor_dir,
  // lamps and computer signals
  output logic [1:0]                lamp_clutch,
  output logic                      lamp_motor,
  output logic                      setup_done,
  output logic                      malfunction_irq,
  // shaft encoders and displays
  input  wire  logic [15:0][9:0]    enc_gray,
  output logic       [15:0]         bcd_disp_a,
  output logic       [15:0]         bcd_disp_b
);
  //////////////////////////////////////////////////////////////////////////
  // input synchronisers and readout units
  logic [16:0]      pins_s;
  logic [15:0][9:0] enc_s;
  logic [1:0]       mode_s;
  logic             go_s;
  logic [5:0]       pdev_s;
  logic [1:0]       pspd_s;
  logic [1:0]       pdir_s;
  logic             ack_dev;
  logic [1:0]       ack_clutch;
  logic             ack_motor;
  logic [9:0]       bin_a;
  logic [9:0]       bin_b;
  logic [3:0]       sel_a;
  logic [3:0]       sel_b;

  sjmcs_sync #(.W(17)) u_sync_pins (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   ({mode_sw, panel_go, panel_dev, panel_spd, panel_dir,
                dev_ack, clutch_ack, motor_ack}),
    .pin_sync (pins_s)
  );
  sjmcs_sync #(.W(160)) u_sync_enc (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_in   (enc_gray),
    .pin_sync (enc_s)
  );
  assign {mode_s, go_s, pdev_s, pspd_s, pdir_s,
          ack_dev, ack_clutch, ack_motor} = pins_s;

  // each readout takes any of the sixteen encoders
  sjmcs_readout u_readout_a (
    .clk     (clk),
    .sys_rst (sys_rst),
    .gray_in (enc_s[sel_a]),
    .bin_reg (bin_a),
    .bcd_reg (bcd_disp_a)
  );
  sjmcs_readout u_readout_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .gray_in (enc_s[sel_b]),
    .bin_reg (bin_b),
    .bcd_reg (bcd_disp_b)
  );

  //////////////////////////////////////////////////////////////////////////
  // panel supervision and command source
  logic                     go_prev_reg, go_prev_next;
  logic [1:0]               mode_prev_reg, mode_prev_next;
  logic [sjmcs_pkg::IDLE_W-1:0] idle_cnt_reg, idle_cnt_next;
  logic                     panel_en_reg, panel_en_next;
  logic                     blocked_reg, blocked_next;
  logic                     go_rise;
  logic                     manual;
  logic                     panel_cmd;
  logic                     bus_cmd;
  logic                     stored_wr;
  logic                     cmd_valid;
  logic                     cmd_flag;
  logic [5:0]               cmd_dev;
  logic [1:0]               cmd_spd;
  logic [1:0]               cmd_dir;
  logic                     cmd_take;
  sjmcs_pkg::sjmcs_state_e  st_reg, st_next;

  // a panel press counts only when enabled and not waiting for a sample
  always_comb begin
    go_rise   = go_s & ~go_prev_reg;
    manual    = (mode_s != sjmcs_pkg::MODE_COMP);
    panel_cmd = go_rise & manual & panel_en_reg & ~blocked_reg;
    bus_cmd   = reg_wr && (reg_addr == sjmcs_pkg::ADDR_CTRL);
    stored_wr = reg_wr && (reg_addr == sjmcs_pkg::ADDR_STATUS)
                && reg_wdata[sjmcs_pkg::ST_STORE];
    cmd_flag  = panel_cmd | reg_wdata[sjmcs_pkg::CW_FLAG];
    cmd_dev   = panel_cmd ? pdev_s : reg_wdata[sjmcs_pkg::CW_DEV +: 6];
    cmd_spd   = panel_cmd ? pspd_s : reg_wdata[sjmcs_pkg::CW_SPD +: 2];
    cmd_dir   = panel_cmd ? pdir_s : reg_wdata[sjmcs_pkg::CW_DIR +: 2];
    // drive words from the computer only count in computer mode
    cmd_valid = panel_cmd | (bus_cmd & (~reg_wdata[sjmcs_pkg::CW_FLAG]
                | ~manual));
    cmd_take  = cmd_valid & ((st_reg == sjmcs_pkg::SQ_IDLE)
                | (st_reg == sjmcs_pkg::SQ_RUN));
    go_prev_next   = go_s;
    mode_prev_next = mode_s;
    idle_cnt_next  = idle_cnt_reg;
    panel_en_next  = panel_en_reg;
    blocked_next   = ((mode_s == sjmcs_pkg::MODE_MANCMP) & panel_cmd)
                     | (blocked_reg & ~stored_wr);
    if (mode_s != mode_prev_reg) begin
      idle_cnt_next = '0;
      panel_en_next = 1'b1;
      blocked_next  = 1'b0;
    end else if (go_rise) begin
      idle_cnt_next = '0;
    end else if (manual && panel_en_reg) begin
      if (idle_cnt_reg == sjmcs_pkg::IDLE_W'(PANEL_IDLE_CYC - 1)) begin
        panel_en_next = 1'b0;
      end else begin
        idle_cnt_next = idle_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      go_prev_reg   <= 1'b0;
      mode_prev_reg <= sjmcs_pkg::MODE_MAN;
      idle_cnt_reg  <= '0;
      panel_en_reg  <= 1'b1;
      blocked_reg   <= 1'b0;
    end else begin
      go_prev_reg   <= go_prev_next;
      mode_prev_reg <= mode_prev_next;
      idle_cnt_reg  <= idle_cnt_next;
      panel_en_reg  <= panel_en_next;
      blocked_reg   <= blocked_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // handshake sequencer
  logic [5:0]                  dev_reg, dev_next, pdev_reg, pdev_next;
  logic [1:0]                  pspd_reg, pspd_next, pdir_reg, pdir_next;
  logic [1:0]                  spd_reg, spd_next, clutch_reg, clutch_next;
  logic                        dev_en_reg, dev_en_next;
  logic                        motor_reg, motor_next, dir_reg, dir_next;
  logic [sjmcs_pkg::TMO_W-1:0] tmo_reg, tmo_next;
  logic                        waiting, tmo_hit, fault_set, done_set;

  // tank drives have one speed; unknown codes keep the present choice
  function automatic logic [1:0] pick_clutch(input logic [1:0] cur,
      input logic [1:0] code, input logic [5:0] dev);
    if (dev >= sjmcs_pkg::TANK_BASE) begin
      pick_clutch = sjmcs_pkg::CLUTCH_SLOW;
    end else if (code == sjmcs_pkg::SPD_SLOW) begin
      pick_clutch = sjmcs_pkg::CLUTCH_SLOW;
    end else if (code == sjmcs_pkg::SPD_FAST) begin
      pick_clutch = sjmcs_pkg::CLUTCH_FAST;
    end else begin
      pick_clutch = cur;
    end
  endfunction : pick_clutch

  function automatic logic pick_dir(input logic cur, input logic [1:0] code);
    if (code == sjmcs_pkg::DIR_OPEN) begin
      pick_dir = 1'b1;
    end else if (code == sjmcs_pkg::DIR_CLOSE) begin
      pick_dir = 1'b0;
    end else begin
      pick_dir = cur;
    end
  endfunction : pick_dir

  // every wait state is bounded; a timeout drops all drives at once
  always_comb begin
    st_next = st_reg;
    dev_next = dev_reg;
    dev_en_next = dev_en_reg;
    pdev_next = pdev_reg;
    pspd_next = pspd_reg;
    pdir_next = pdir_reg;
    spd_next = spd_reg;
    clutch_next = clutch_reg;
    motor_next = motor_reg;
    dir_next = dir_reg;
    fault_set = 1'b0;
    done_set = 1'b0;
    waiting = (st_reg != sjmcs_pkg::SQ_IDLE)
              && (st_reg != sjmcs_pkg::SQ_RUN);
    tmo_hit = waiting && (tmo_reg == sjmcs_pkg::TMO_W'(ACK_TMO_CYC - 1));
    if (tmo_hit) begin
      st_next = sjmcs_pkg::SQ_IDLE;
      dev_en_next = 1'b0;
      clutch_next = '0;
      motor_next = 1'b0;
      fault_set = 1'b1;
    end else begin
      case (st_reg)
        sjmcs_pkg::SQ_IDLE: begin
          if (cmd_take && cmd_flag) begin
            dev_next = cmd_dev;
            dev_en_next = 1'b1;
            spd_next = pick_clutch(spd_reg, cmd_spd, cmd_dev);
            dir_next = pick_dir(dir_reg, cmd_dir);
            st_next = sjmcs_pkg::SQ_DEV;
          end
        end
        sjmcs_pkg::SQ_DEV: begin
          if (ack_dev) begin
            clutch_next = spd_reg;
            st_next = sjmcs_pkg::SQ_CLU;
          end
        end
        sjmcs_pkg::SQ_CLU: begin
          if (ack_clutch == clutch_reg) begin
            motor_next = 1'b1;
            st_next = sjmcs_pkg::SQ_MOT;
          end
        end
        sjmcs_pkg::SQ_MOT: begin
          if (ack_motor) begin
            done_set = 1'b1;
            st_next = sjmcs_pkg::SQ_RUN;
          end
        end
        sjmcs_pkg::SQ_RUN: begin
          if (cmd_take && cmd_flag) begin
            pdev_next = cmd_dev;
            pspd_next = cmd_spd;
            pdir_next = cmd_dir;
            motor_next = 1'b0;
            st_next = sjmcs_pkg::SQ_STOP;
          end
        end
        sjmcs_pkg::SQ_STOP: begin
          if (!ack_motor) begin
            spd_next = pick_clutch(spd_reg, pspd_reg, pdev_reg);
            dir_next = pick_dir(dir_reg, pdir_reg);
            if (pdev_reg != dev_reg) begin
              dev_next = pdev_reg;
              clutch_next = '0;
              st_next = sjmcs_pkg::SQ_DEV;
            end else begin
              clutch_next = pick_clutch(spd_reg, pspd_reg, pdev_reg);
              st_next = sjmcs_pkg::SQ_CLU;
            end
          end
        end
        default: begin
          st_next = sjmcs_pkg::SQ_IDLE;
        end
      endcase
    end
    tmo_next = (waiting && st_next == st_reg) ? tmo_reg + 1'b1 : '0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg     <= sjmcs_pkg::SQ_IDLE;
      dev_reg    <= '0;
      dev_en_reg <= 1'b0;
      pdev_reg   <= '0;
      pspd_reg   <= '0;
      pdir_reg   <= '0;
      spd_reg    <= sjmcs_pkg::CLUTCH_SLOW;
      clutch_reg <= '0;
      motor_reg  <= 1'b0;
      dir_reg    <= 1'b0;
      tmo_reg    <= '0;
    end else begin
      st_reg     <= st_next;
      dev_reg    <= dev_next;
      dev_en_reg <= dev_en_next;
      pdev_reg   <= pdev_next;
      pspd_reg   <= pspd_next;
      pdir_reg   <= pdir_next;
      spd_reg    <= spd_next;
      clutch_reg <= clutch_next;
      motor_reg  <= motor_next;
      dir_reg    <= dir_next;
      tmo_reg    <= tmo_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers seen by the computer
  logic [sjmcs_pkg::CW_W-1:0] cw_reg, cw_next;
  logic [sjmcs_pkg::ES_W-1:0] es_reg, es_next;
  logic [5:0]                 fb_dev_reg, fb_dev_next;
  logic                       fault_reg, fault_next, done_reg, done_next;
  logic [15:0]                rdata_next;
  logic                       st_wr;

  // set wins over a clear arriving in the same cycle
  always_comb begin
    st_wr = reg_wr && (reg_addr == sjmcs_pkg::ADDR_STATUS);
    cw_next = bus_cmd ? reg_wdata[sjmcs_pkg::CW_W-1:0] : cw_reg;
    es_next = (reg_wr && reg_addr == sjmcs_pkg::ADDR_ENCSEL)
              ? reg_wdata[sjmcs_pkg::ES_W-1:0] : es_reg;
    fb_dev_next = cmd_take ? cmd_dev : fb_dev_reg;
    fault_next = fault_set
                 | (fault_reg & ~(st_wr & reg_wdata[sjmcs_pkg::ST_FAULT]));
    done_next = done_set
                | (done_reg & ~(st_wr & reg_wdata[sjmcs_pkg::ST_DONE]));
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        sjmcs_pkg::ADDR_CTRL:   rdata_next = {5'h00, cw_reg};
        sjmcs_pkg::ADDR_STATUS: begin
          rdata_next[sjmcs_pkg::ST_FAULT] = fault_reg;
          rdata_next[sjmcs_pkg::ST_DONE]  = done_reg;
          rdata_next[sjmcs_pkg::ST_MOTOR] = ack_motor;
          rdata_next[sjmcs_pkg::ST_PANEL] = panel_en_reg;
          rdata_next[sjmcs_pkg::ST_BLOCK] = blocked_reg;
          rdata_next[sjmcs_pkg::ST_MODE +: 2] = mode_s;
          rdata_next[sjmcs_pkg::ST_BUSY]  = waiting;
        end
        sjmcs_pkg::ADDR_FEED: begin
          rdata_next = {fb_dev_reg, es_reg[sjmcs_pkg::ES_SRC]
                        ? bin_b : bin_a};
        end
        sjmcs_pkg::ADDR_ENCSEL: rdata_next = {7'h00, es_reg};
        default:                rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cw_reg     <= '0;
      es_reg     <= sjmcs_pkg::ENCSEL_RST;
      fb_dev_reg <= '0;
      fault_reg  <= 1'b0;
      done_reg   <= 1'b0;
      reg_rdata  <= '0;
    end else begin
      cw_reg     <= cw_next;
      es_reg     <= es_next;
      fb_dev_reg <= fb_dev_next;
      fault_reg  <= fault_next;
      done_reg   <= done_next;
      reg_rdata  <= rdata_next;
    end
  end

  // in manual modes the selected device also feeds readout A
  assign sel_a = manual ? dev_reg[3:0] : es_reg[sjmcs_pkg::ES_A +: 4];
  assign sel_b = es_reg[sjmcs_pkg::ES_B +: 4];
  assign dev_sel = dev_reg;
  assign dev_sel_en = dev_en_reg;
  assign clutch_on = clutch_reg;
  assign motor_on = motor_reg;
  assign motor_dir = dir_reg;
  assign lamp_clutch = ack_clutch;
  assign lamp_motor = ack_motor;
  assign setup_done = done_reg;
  assign malfunction_irq = fault_reg;
  assign panel_enabled = panel_en_reg;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  read_no_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == sjmcs_pkg::SQ_IDLE && cmd_take && !cmd_flag && !tmo_hit)
    |=> (st_reg == sjmcs_pkg::SQ_IDLE) && !motor_reg && clutch_reg == '0)
    else $error("read word started a drive");
  dev_first_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == sjmcs_pkg::SQ_IDLE && cmd_take && cmd_flag)
    |=> dev_en_reg && clutch_reg == '0 && !motor_reg
        && st_reg == sjmcs_pkg::SQ_DEV)
    else $error("device not selected first");
  clutch_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == sjmcs_pkg::SQ_DEV && ack_dev && !tmo_hit)
    |=> clutch_reg == spd_reg && clutch_reg != '0)
    else $error("clutch not energised after device ack");
  motor_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(motor_reg) |-> $past(st_reg == sjmcs_pkg::SQ_CLU)
                         && $past(ack_clutch) == clutch_reg)
    else $error("motor started without clutch ack");
  done_report_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == sjmcs_pkg::SQ_MOT && ack_motor && !tmo_hit)
    |=> done_reg ##1 done_reg || $past(st_wr))
    else $error("setup done not reported");
  change_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == sjmcs_pkg::SQ_RUN && cmd_take && cmd_flag)
    |=> !motor_reg && st_reg == sjmcs_pkg::SQ_STOP)
    else $error("motor not stopped on new word");
  ack_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == sjmcs_pkg::SQ_CLU && ack_clutch != clutch_reg && !tmo_hit)
    |=> st_reg == sjmcs_pkg::SQ_CLU && !motor_reg)
    else $error("advanced without acknowledge");
  timeout_a: assert property (@(posedge clk) disable iff (sys_rst)
    tmo_hit |=> fault_reg && st_reg == sjmcs_pkg::SQ_IDLE
                && !motor_reg && !dev_en_reg)
    else $error("timeout did not raise malfunction");
  tank_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
    clutch_reg == sjmcs_pkg::CLUTCH_FAST |-> dev_reg < sjmcs_pkg::TANK_BASE)
    else $error("tank drive on fast clutch");
  panel_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    (panel_cmd && mode_s == sjmcs_pkg::MODE_MANCMP
     && mode_s == mode_prev_reg) |=> blocked_reg && !panel_cmd)
    else $error("panel press did not block");
  setup_c: cover property (@(posedge clk) disable iff (sys_rst)
    st_reg == sjmcs_pkg::SQ_MOT ##1 st_reg == sjmcs_pkg::SQ_RUN);
  fault_c: cover property (@(posedge clk) disable iff (sys_rst) tmo_hit);
  change_c: cover property (@(posedge clk) disable iff (sys_rst)
    st_reg == sjmcs_pkg::SQ_STOP ##1 st_reg == sjmcs_pkg::SQ_CLU);
endmodule : sjmcs_selector

// file: pkg/sjmcs_pkg.sv
// constants for the slit jaw motor and clutch selector
// Notes on behaviour
// - control word: flag, device, speed, direction
// - read word drives nothing, only feedback sampling
// - control word selects device, awaits acknowledge
// - then chosen speed clutch on, awaits acknowledge
// - then motor on; running reports setup done
// - new word stops motor, changes differing fields
// - every command waits for its acknowledge
// - half-second acknowledge timeout raises malfunction
// - feedback word: device code plus ten bits
// - any of sixteen encoders to either readout
// - readout converts gray to binary and BCD
// - three panel modes chosen by mode switch
// - manual-computer mode blocks until sample stored
// - manual modes disable panel after three minutes
// - in manual modes selection attaches readout A and drive together
// - drive commands from panel or computer
// - clutch and motor acknowledges also light the lamps
// - tank devices run at slow speed only
package sjmcs_pkg;
  // clock and timing
  localparam int     CLK_HZ         = 25_000_000;
  localparam int     ACK_TMO_MS     = 500;
  localparam int     ACK_TMO_CYC    = CLK_HZ / 1000 * ACK_TMO_MS;
  localparam int     PANEL_IDLE_MIN = 3;
  localparam longint PANEL_IDLE_CYC = 64'(CLK_HZ) * 60 * PANEL_IDLE_MIN;
  localparam int     TMO_W          = 24;
  localparam int     IDLE_W         = 33;
  // register indices on the plain port
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_FEED   = 4'h2;
  localparam logic [3:0] ADDR_ENCSEL = 4'h3;
  // control word fields
  localparam int CW_W    = 11;
  localparam int CW_FLAG = 10;
  localparam int CW_DEV  = 4;
  localparam int CW_SPD  = 2;
  localparam int CW_DIR  = 0;
  // status fields
  localparam int ST_FAULT = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_MOTOR = 2;
  localparam int ST_PANEL = 3;
  localparam int ST_BLOCK = 4;
  localparam int ST_MODE  = 5;
  localparam int ST_BUSY  = 7;
  localparam int ST_STORE = 2;
  // encoder select fields
  localparam int ES_W   = 9;
  localparam int ES_A   = 0;
  localparam int ES_B   = 4;
  localparam int ES_SRC = 8;
  localparam logic [8:0] ENCSEL_RST = 9'h010;
  // speed, clutch, direction and mode codes
  localparam logic [1:0] SPD_SLOW    = 2'h1;
  localparam logic [1:0] SPD_FAST    = 2'h2;
  localparam logic [1:0] CLUTCH_SLOW = 2'h1;
  localparam logic [1:0] CLUTCH_FAST = 2'h2;
  localparam logic [1:0] DIR_OPEN    = 2'h1;
  localparam logic [1:0] DIR_CLOSE   = 2'h2;
  localparam logic [1:0] MODE_MAN    = 2'h0;
  localparam logic [1:0] MODE_MANCMP = 2'h1;
  localparam logic [1:0] MODE_COMP   = 2'h2;
  localparam logic [5:0] TANK_BASE   = 6'h30;
  // encoder geometry
  localparam int ENC_N = 16;
  localparam int POS_W = 10;
  localparam int BCD_W = 16;
  // sequencer states
  typedef enum logic [5:0] {
    SQ_IDLE = 6'h01,
    SQ_DEV  = 6'h02,
    SQ_CLU  = 6'h04,
    SQ_MOT  = 6'h08,
    SQ_RUN  = 6'h10,
    SQ_STOP = 6'h20
  } sjmcs_state_e;
endpackage : sjmcs_pkg

// file: design/sjmcs_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module sjmcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire  logic         clk,
  input  wire  logic         sys_rst,
  // pins and their synchronised copy
  input  wire  logic [W-1:0] pin_in,
  output logic       [W-1:0] pin_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  // the first stage feeds only the second
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= meta_next;
      pin_sync <= sync_next;
    end
  end
endmodule : sjmcs_sync

// file: design/sjmcs_readout.sv
// position readout unit: gray to binary to BCD
`timescale 1ns/1ns
module sjmcs_readout (
  // clock and reset
  input  wire  logic                          clk,
  input  wire  logic                          sys_rst,
  // gray coded position in, binary and BCD out
  input  wire  logic [sjmcs_pkg::POS_W-1:0]   gray_in,
  output logic       [sjmcs_pkg::POS_W-1:0]   bin_reg,
  output logic       [sjmcs_pkg::BCD_W-1:0]   bcd_reg
);
  logic [sjmcs_pkg::POS_W-1:0] bin_next;
  logic [sjmcs_pkg::BCD_W-1:0] bcd_next;

  // gray decode then shift-add-3; max 1023 fits four digits
  always_comb begin
    bin_next[sjmcs_pkg::POS_W-1] = gray_in[sjmcs_pkg::POS_W-1];
    for (int i = sjmcs_pkg::POS_W - 2; i >= 0; i--) begin
      bin_next[i] = bin_next[i+1] ^ gray_in[i];
    end
    bcd_next = '0;
    for (int i = sjmcs_pkg::POS_W - 1; i >= 0; i--) begin
      for (int d = 0; d < 4; d++) begin
        if (bcd_next[d*4 +: 4] > 4'h4) begin
          bcd_next[d*4 +: 4] = bcd_next[d*4 +: 4] + 4'h3;
        end
      end
      bcd_next = {bcd_next[sjmcs_pkg::BCD_W-2:0], bin_next[i]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bin_reg <= '0;
      bcd_reg <= '0;
    end else begin
      bin_reg <= bin_next;
      bcd_reg <= bcd_next;
    end
  end
endmodule : sjmcs_readout

// file: tb/sjmcs_partner.sv
// partner model: acknowledge feedback of device, clutches and motor
`timescale 1ns/1ns
module sjmcs_partner (
  // clock, reset and fault control
  input  wire  logic       clk,
  input  wire  logic       sys_rst,
  input  wire  logic       stall,
  // commands from the selector
  input  wire  logic       dev_sel_en,
  input  wire  logic [1:0] clutch_on,
  input  wire  logic       motor_on,
  // acknowledges back to the selector
  output logic             dev_ack,
  output logic [1:0]       clutch_ack,
  output logic             motor_ack
);
  //////////////////////////////////////////////////////////////////////////
  // acks follow commands a cycle late; a stall keeps new acks from rising
  // but lets held ones drop, so only the next awaited step can time out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_ack    <= 1'b0;
      clutch_ack <= 2'h0;
      motor_ack  <= 1'b0;
    end else begin
      dev_ack    <= dev_sel_en & (dev_ack | ~stall);
      clutch_ack <= clutch_on & (clutch_ack | {2{~stall}});
      motor_ack  <= motor_on & (motor_ack | ~stall);
    end
  end
endmodule : sjmcs_partner

// file: tb/tb_top.sv
// self-checking bench of the selector against the acknowledge partner
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
  logic             clk, sys_rst, reg_wr, reg_rd, stall;
  logic [3:0]       reg_addr;
  logic [15:0]      reg_wdata, reg_rdata, bcd_a, bcd_b, d;
  logic [1:0]       mode_sw, clutch_ack, clutch_on, lamp_clutch;
  logic             dev_ack, motor_ack, dev_sel_en, motor_on, motor_dir;
  logic             panel_enabled, lamp_motor, setup_done, malfunction_irq;
  logic [5:0]       dev_sel, pdev;
  logic [1:0]       pspd, pdir;
  logic             pgo;
  logic [15:0][9:0] enc;
  int               bad_count, n_checks, dv, b, e;
  //////////////////////////////////////////////////////////////////////////
  // short timeouts keep the run brief; panel pins matter in manual modes
  sjmcs_selector #(.ACK_TMO_CYC(20), .PANEL_IDLE_CYC(50)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_sw(mode_sw), .panel_go(pgo),
    .panel_dev(pdev), .panel_spd(pspd), .panel_dir(pdir),
    .panel_enabled(panel_enabled), .dev_ack(dev_ack),
    .clutch_ack(clutch_ack), .motor_ack(motor_ack), .dev_sel(dev_sel),
    .dev_sel_en(dev_sel_en), .clutch_on(clutch_on), .motor_on(motor_on),
    .motor_dir(motor_dir), .lamp_clutch(lamp_clutch),
    .lamp_motor(lamp_motor), .setup_done(setup_done),
    .malfunction_irq(malfunction_irq), .enc_gray(enc),
    .bcd_disp_a(bcd_a), .bcd_disp_b(bcd_b));
  sjmcs_partner i_far (.clk(clk), .sys_rst(sys_rst), .stall(stall),
    .dev_sel_en(dev_sel_en), .clutch_on(clutch_on), .motor_on(motor_on),
    .dev_ack(dev_ack), .clutch_ack(clutch_ack), .motor_ack(motor_ack));
  //////////////////////////////////////////////////////////////////////////
  // clock
  always #20 clk = ~clk;
  // bus cycles and bounded waits
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 v = reg_rdata; // data stand only in the cycle after the strobe
  endtask : rd
  task automatic wt(input bit m);
    int k;
    k = 0;
    while (((m ? malfunction_irq : setup_done) !== 1'b1) && k < 200) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 200) begin bad_count++; $display("CHECK FAILED %0t hang", $time);
      test_done(); end
  endtask : wt
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////
  // main sequence: idle read path, setup, change, stalled acknowledge
  initial begin
    clk = 0; sys_rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0;
    reg_wdata = 0; mode_sw = 2'h2; stall = 0; bad_count = 0; n_checks = 0;
    pgo = 0; pdev = 0; pspd = 0; pdir = 0;
    void'($urandom(44));
    for (int i = 0; i < 16; i++) enc[i] = 10'($urandom);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'h1, d); `CHK(d, 16'h0048)
    rd(4'h9, d); `CHK(d, 16'h0000)
    dv = $urandom_range(0, 47); b = 0;
    for (int s = 0; s < 10; s++) b ^= int'(enc[0]) >> s;
    e = (b / 1000 << 12) | (b / 100 % 10 << 8) | (b / 10 % 10 << 4) | b % 10;
    wr(4'h0, 16'(dv << 4)); wr(4'h3, 16'h0100); // feed from readout b
    rd(4'h2, d); `CHK(d, 16'(dv << 10 | b))
    `CHK({dev_sel_en, motor_on}, 2'h0)
    `CHK(bcd_a, 16'(e))
    `CHK(bcd_b, 16'(e))
    $display("test 1 done");
    wr(4'h0, 16'({1'b1, 6'(dv), sjmcs_pkg::SPD_FAST, sjmcs_pkg::DIR_OPEN}));
    wt(0);
    `CHK({dev_sel, dev_sel_en}, {6'(dv), 1'b1})
    `CHK(clutch_on, sjmcs_pkg::CLUTCH_FAST)
    `CHK({motor_on, motor_dir}, 2'h3)
    `CHK({lamp_clutch, lamp_motor}, 3'h5)
    $display("test 2 done");
    wr(4'h1, 16'h0002); rd(4'h1, d); `CHK(d[1], 1'b0)
    wr(4'h0, 16'({1'b1, 6'(dv), sjmcs_pkg::SPD_SLOW, 2'h3}));
    wt(0);
    `CHK(clutch_on, sjmcs_pkg::CLUTCH_SLOW)
    `CHK(motor_dir, 1'b1)
    $display("test 3 done");
    @(posedge clk) stall <= 1'b1;
    wr(4'h0, 16'({1'b1, 6'(dv ^ 1), sjmcs_pkg::SPD_FAST, 2'h0}));
    wt(1);
    `CHK({dev_sel_en, clutch_on, motor_on}, 4'h0)
    rd(4'h1, d); `CHK(d[0], 1'b1)
    $display("test 4 done");
    @(posedge clk) begin stall <= 1'b0; mode_sw <= sjmcs_pkg::MODE_MANCMP;
      pdev <= 6'(dv); pspd <= sjmcs_pkg::SPD_FAST;
      pdir <= sjmcs_pkg::DIR_CLOSE; end
    wr(4'h1, 16'h0003);
    @(posedge clk) pgo <= 1'b1;
    wt(0);
    `CHK({dev_sel, clutch_on, motor_dir}, {6'(dv), 2'h2, 1'b0})
    rd(4'h1, d); `CHK(d, 16'h003E)
    wr(4'h1, 16'h0004); rd(4'h1, d); `CHK(d[4], 1'b0)
    repeat (60) @(posedge clk);
    `CHK(panel_enabled, 1'b0)
    $display("test 5 done");
    test_done();
  end
endmodule : tb_top
